// File: logic/swrs_counter.sv
// Purpose: Loadable down counter that times the entry, sequence and sample phases.
// Assumes: A load of N-1 gives a phase of N cycles.
// Notes: Holds at zero until the next load.
`timescale 1ns/100ps
module swrs_counter (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Load and status.
    input wire logic load,
    input wire logic [swrs_pkg::CNT_W-1:0] load_value,
    output logic done
);
    import swrs_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } swrs_counter_type;

    swrs_counter_type cur;
    swrs_counter_type next_cur;

    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.count = load_value;
        end else if (cur.count != '0) begin
            next_cur.count = cur.count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur.count <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = (cur.count == '0);

endmodule : swrs_counter

// File: logic/swrs_pkg.sv
// Purpose: Shared constants and types for the warm reset sequencer.
// Assumes: mclk at 250 MHz; one half_clock_unit is half an mclk period.
// Notes: Times are kept in half clock units and turned into mclk cycles here.
package swrs_pkg;

    // Timing in half clock units, and the mclk cycles derived from them.
    localparam int HALF_UNITS_PER_CYCLE = 2;
    localparam int DETECT_TCL = 4;
    localparam int ENTRY_TCL = 12;
    localparam int SEQ_TCL = 1024;
    localparam int SAMPLE_TCL = 8;
    localparam int CLOSE_TCL = 3;
    localparam int DETECT_CYC = (DETECT_TCL + HALF_UNITS_PER_CYCLE - 1) / HALF_UNITS_PER_CYCLE;
    localparam int ENTRY_CYC = ENTRY_TCL / HALF_UNITS_PER_CYCLE;
    localparam int SEQ_CYC = SEQ_TCL / HALF_UNITS_PER_CYCLE;
    localparam int SAMPLE_CYC = SAMPLE_TCL / HALF_UNITS_PER_CYCLE;
    localparam int CLOSE_CYC = (CLOSE_TCL + HALF_UNITS_PER_CYCLE - 1) / HALF_UNITS_PER_CYCLE;

    // Phase counter.
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] ENTRY_LOAD = CNT_W'(ENTRY_CYC - 1);
    localparam logic [CNT_W-1:0] SEQ_LOAD = CNT_W'(SEQ_CYC - 1);
    localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYC - 1);
    localparam logic [1:0] DETECT_LAST = 2'(DETECT_CYC - 1);
    localparam logic [1:0] CLOSE_LAST = 2'(CLOSE_CYC - 1);

    // Configuration port fields.
    localparam int CFG_W = 16;
    localparam int CLK_OPT_HI = 15;
    localparam int CLK_OPT_LO = 13;
    localparam int SW_LATCH_HI = 12;
    localparam int SW_LATCH_LO = 8;
    localparam int SW_SET_HI = 7;
    localparam int SW_SET_LO = 2;
    localparam logic [CFG_W-1:0] SYS_CONFIG_RESET = 16'h0000;

    // Restart point of instruction fetch.
    localparam logic [23:0] FETCH_START_ADDR = 24'h000000;

    // Synchroniser width and idle level of the sampled pins.
    localparam int SYNC_W = 20;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 20'hfffff;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ENTRY = 7'h02,
        ST_SEQ = 7'h04,
        ST_SAMPLE = 7'h08,
        ST_EXTEND = 7'h10,
        ST_ASYNC = 7'h20,
        ST_SPARE = 7'h40
    } swrs_state_type;

endpackage : swrs_pkg

// File: logic/swrs_sequencer.sv
// Purpose: Warm reset sequencer: detection, entry window, internal sequence, exit.
// Assumes: Filtered reset, reset pin, mode pin and config port are asynchronous pins.
// Notes: The asynchronous reset is modelled on mclk, so it lags by the synchroniser.
//
// Overview of operation
// - Warm reset when reset low, mode pin high.
// - On request float I/O, drive reset out.
// - Twelve half units cancel holds, finish access.
// - Abort any running external bus cycle.
// - Pull-down only if enabled; clear enable after.
// - Run internal sequence of 1024 half units.
// - Sample filtered reset later: short or long.
// - Long reset opens clock option bits.
// - Close clock bits after filtered reset high.
// - Bidirectional pull-down held until sequence ends.
// - Extend until reset high and flash ready; here flash ready is only awaited for internal boot.
// - On exit latch config, idle the strobes.
// - Fetch restarts at address zero, segment zero.
// - Mode pin pull-down while reset pin low.
// - Mode pin low during hardware reset: asynchronous.
// - Asynchronous reset completes even if mode returns.
// - Software reset ignores the mode pin level.
// - Mode pin judged against filtered reset only.
// - Software reset instruction starts sequence anytime; here it is only taken in ST_IDLE.
// - Software reset latches 12..8, sets 7..2.
// - Software bidirectional drive only while mode high.
// - Asynchronous reset aborts, floats, pulls config high.
`timescale 1ns/100ps
module swrs_sequencer (
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic rst,
    // Reset pin, filtered reset and mode pin.
    input wire logic filtered_reset_n,
    input wire logic reset_in_n_i,
    output logic reset_in_n_o,
    output logic reset_in_n_oe,
    input wire logic reset_mode_pin,
    output logic reset_mode_pd_en,
    output logic reset_out_n,
    // Boot selection and configuration port.
    input wire logic external_access_sel_n,
    input wire logic flash_init_done,
    input wire logic [swrs_pkg::CFG_W-1:0] config_port,
    output logic config_pull_high,
    output logic clock_opt_transparent,
    output logic [swrs_pkg::CFG_W-1:0] system_config,
    // Software side.
    input wire logic software_reset_instr,
    input wire logic end_of_init,
    input wire logic bidir_write,
    input wire logic bidir_write_value,
    output logic bidir_reset_enable,
    // Core and bus control.
    output logic io_hiz,
    output logic cancel_holds,
    output logic abort_ext_cycle,
    output logic internal_reset,
    output logic ale,
    output logic rd_n,
    output logic write_strobe_n,
    output logic [23:0] fetch_addr,
    output logic fetch_start,
    // Reset flags.
    output logic short_reset_flag,
    output logic long_reset_flag,
    output logic async_reset_flag
);
    import swrs_pkg::*;

    typedef struct packed {
        swrs_state_type state;
        logic [1:0] low_cnt;
        logic [1:0] close_cnt;
        logic is_sw;
        logic bidir_armed;
        logic drive_level;
        logic pin_oe;
        logic mode_pd;
        logic out_n;
        logic pull_high;
        logic transparent;
        logic [CFG_W-1:0] sys_cfg;
        logic bidir_en;
        logic hiz;
        logic cancel;
        logic abort;
        logic int_reset;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [23:0] fetch_addr;
        logic fetch_start;
        logic short_flag;
        logic long_flag;
        logic async_flag;
    } swrs_seq_type;

    swrs_seq_type cur;
    swrs_seq_type next_cur;
    logic [SYNC_W-1:0] sync_out;
    logic flt_n;
    logic pin_n;
    logic mode;
    logic ext_sel_n;
    logic [CFG_W-1:0] cfg;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_done;
    logic hw_req;
    logic hw_active;

    swrs_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({filtered_reset_n, reset_in_n_i, reset_mode_pin, external_access_sel_n, config_port}),
        .sync_out(sync_out)
    );

    assign {flt_n, pin_n, mode, ext_sel_n, cfg} = sync_out;

    swrs_counter u_counter (
        .mclk(mclk),
        .rst(rst),
        .load(cnt_load),
        .load_value(cnt_value),
        .done(cnt_done)
    );

    // Low must be seen on the filtered line at DETECT_CYC consecutive mclk edges.
    assign hw_req = !flt_n && (cur.low_cnt == DETECT_LAST);
    assign hw_active = !cur.is_sw && (cur.state != ST_IDLE) && (cur.state != ST_ASYNC);

    always_comb begin
        next_cur = cur;
        cnt_load = 1'b0;
        cnt_value = '0;
        next_cur.abort = 1'b0;
        next_cur.fetch_start = 1'b0;
        next_cur.low_cnt = (!flt_n && cur.low_cnt != DETECT_LAST) ? cur.low_cnt + 1'b1 : cur.low_cnt;
        if (flt_n) begin
            next_cur.low_cnt = '0;
        end
        unique case (cur.state)
            ST_IDLE: begin
                if (end_of_init) begin
                    next_cur.out_n = 1'b1;
                end
                if (bidir_write) begin
                    next_cur.bidir_en = bidir_write_value;
                end
                if (hw_req || software_reset_instr) begin
                    next_cur.out_n = 1'b0;
                    next_cur.hiz = 1'b1;
                    next_cur.int_reset = 1'b1;
                    next_cur.short_flag = 1'b0;
                    next_cur.long_flag = 1'b0;
                    next_cur.async_flag = 1'b0;
                    next_cur.is_sw = !hw_req;
                    next_cur.bidir_armed = cur.bidir_en;
                end
                if (hw_req && !mode) begin
                    next_cur.state = ST_ASYNC;
                    next_cur.async_flag = 1'b1;
                    next_cur.abort = 1'b1;
                    next_cur.pull_high = 1'b1;
                    next_cur.bidir_en = 1'b0;
                    next_cur.bidir_armed = 1'b0;
                end else if (hw_req || software_reset_instr) begin
                    next_cur.state = ST_ENTRY;
                    next_cur.abort = 1'b1;
                    next_cur.cancel = 1'b1;
                    cnt_load = 1'b1;
                    cnt_value = ENTRY_LOAD;
                end
            end
            ST_ENTRY: begin
                if (cnt_done) begin
                    next_cur.state = ST_SEQ;
                    next_cur.cancel = 1'b0;
                    cnt_load = 1'b1;
                    cnt_value = SEQ_LOAD;
                end
            end
            ST_SEQ: begin
                if (cnt_done) begin
                    next_cur.state = ST_SAMPLE;
                    next_cur.bidir_armed = 1'b0;
                    next_cur.bidir_en = 1'b0;
                    cnt_load = 1'b1;
                    cnt_value = SAMPLE_LOAD;
                end
            end
            ST_SAMPLE: begin
                if (cnt_done) begin
                    next_cur.state = ST_EXTEND;
                    next_cur.close_cnt = '0;
                    next_cur.short_flag = 1'b1;
                    if (!flt_n && !cur.is_sw) begin
                        next_cur.long_flag = 1'b1;
                        next_cur.transparent = 1'b1;
                    end
                end
            end
            ST_EXTEND: begin
                if (cur.transparent) begin
                    next_cur.sys_cfg[CLK_OPT_HI:CLK_OPT_LO] = cfg[CLK_OPT_HI:CLK_OPT_LO];
                    if (flt_n) begin
                        next_cur.close_cnt = cur.close_cnt + 1'b1;
                        if (cur.close_cnt == CLOSE_LAST) begin
                            next_cur.transparent = 1'b0;
                        end
                    end else begin
                        next_cur.close_cnt = '0;
                    end
                end else if (flt_n && (!ext_sel_n || flash_init_done)) begin
                    next_cur.state = ST_IDLE;
                    if (cur.is_sw) begin
                        next_cur.sys_cfg[SW_LATCH_HI:SW_LATCH_LO] = cfg[SW_LATCH_HI:SW_LATCH_LO];
                        next_cur.sys_cfg[SW_SET_HI:SW_SET_LO] = '1;
                    end else begin
                        next_cur.sys_cfg = cfg;
                    end
                    next_cur.ale = 1'b0;
                    next_cur.rd_n = 1'b1;
                    next_cur.wr_n = 1'b1;
                    next_cur.fetch_addr = FETCH_START_ADDR;
                    next_cur.fetch_start = 1'b1;
                    next_cur.int_reset = 1'b0;
                    next_cur.hiz = 1'b0;
                    next_cur.pull_high = 1'b0;
                    // An asynchronous turn inside the entry window would otherwise leave this set.
                    next_cur.cancel = 1'b0;
                    next_cur.is_sw = 1'b0;
                end
            end
            ST_ASYNC: begin
                // The asynchronous path waits for release, whatever the mode pin does.
                if (flt_n) begin
                    next_cur.state = ST_EXTEND;
                    next_cur.transparent = 1'b0;
                    next_cur.is_sw = 1'b0;
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
        // A hardware warm reset whose mode pin falls while the filtered line is low turns asynchronous.
        if (hw_active && !flt_n && !mode) begin
            next_cur.state = ST_ASYNC;
            next_cur.async_flag = 1'b1;
            next_cur.abort = 1'b1;
            next_cur.hiz = 1'b1;
            next_cur.pull_high = 1'b1;
            next_cur.int_reset = 1'b1;
            next_cur.transparent = 1'b0;
            next_cur.bidir_armed = 1'b0;
            next_cur.bidir_en = 1'b0;
        end
        // Software drive is dropped for good once the mode pin goes low.
        if (cur.is_sw && !mode) begin
            next_cur.bidir_armed = 1'b0;
        end
        next_cur.drive_level = 1'b0;
        next_cur.pin_oe = next_cur.bidir_armed && (!next_cur.is_sw || mode);
        next_cur.mode_pd = !pin_n || next_cur.pin_oe;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur <= '0;
            cur.state <= ST_IDLE;
            cur.sys_cfg <= SYS_CONFIG_RESET;
            cur.rd_n <= 1'b1;
            cur.wr_n <= 1'b1;
            cur.fetch_addr <= FETCH_START_ADDR;
            cur.bidir_en <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign reset_in_n_o = cur.drive_level;
    assign reset_in_n_oe = cur.pin_oe;
    assign reset_mode_pd_en = cur.mode_pd;
    assign reset_out_n = cur.out_n;
    assign config_pull_high = cur.pull_high;
    assign clock_opt_transparent = cur.transparent;
    assign system_config = cur.sys_cfg;
    assign bidir_reset_enable = cur.bidir_en;
    assign io_hiz = cur.hiz;
    assign cancel_holds = cur.cancel;
    assign abort_ext_cycle = cur.abort;
    assign internal_reset = cur.int_reset;
    assign ale = cur.ale;
    assign rd_n = cur.rd_n;
    assign write_strobe_n = cur.wr_n;
    assign fetch_addr = cur.fetch_addr;
    assign fetch_start = cur.fetch_start;
    assign short_reset_flag = cur.short_flag;
    assign long_reset_flag = cur.long_flag;
    assign async_reset_flag = cur.async_flag;

endmodule : swrs_sequencer

// File: logic/swrs_sync.sv
// Purpose: Two flip-flop synchroniser for pins entering the mclk domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module swrs_sync (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Pins in and synchronised levels out.
    input wire logic [swrs_pkg::SYNC_W-1:0] async_in,
    output logic [swrs_pkg::SYNC_W-1:0] sync_out
);
    import swrs_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } swrs_sync_type;

    swrs_sync_type cur;
    swrs_sync_type next_cur;

    always_comb begin
        next_cur.stage1 = async_in;
        next_cur.stage2 = cur.stage1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur.stage1 <= SYNC_INIT;
            cur.stage2 <= SYNC_INIT;
        end else begin
            cur <= next_cur;
        end
    end

    assign sync_out = cur.stage2;

endmodule : swrs_sync

// File: testbench/swrs_partner.sv
// Purpose: Far side model: reset pin with pull-up, input filter, mode pin.
// Assumes: The bench commands a press of the reset pin and a drop of the mode pin.
// Notes: The filter is a plain delay, so it never swallows a valid pulse.
`timescale 1ns/100ps
module swrs_partner #(
    parameter int FILT = 1
) (
    // Clock.
    input wire logic mclk,
    // Bench commands.
    input wire logic press,
    input wire logic mode_drop,
    // Device pin drive.
    input wire logic reset_in_n_o,
    input wire logic reset_in_n_oe,
    // Pin levels seen by the device.
    output logic reset_in_n_i,
    output logic filtered_reset_n,
    output logic reset_mode_pin
);
    logic [FILT-1:0] taps = '1;
    logic [1:0] low_cnt = 2'h0;

    // A press is held for two extra cycles so a short command still counts.
    always @(negedge mclk) begin
        low_cnt <= press ? 2'h2 : (low_cnt != 2'h0 ? low_cnt - 2'h1 : 2'h0);
        taps <= FILT'({taps, reset_in_n_i});
    end
    // The pull-up wins when nobody pulls the pin low.
    assign reset_in_n_i = !(press || low_cnt != 2'h0 || (reset_in_n_oe && !reset_in_n_o));
    assign filtered_reset_n = taps[FILT-1];
    assign reset_mode_pin = !mode_drop;
endmodule : swrs_partner

// File: testbench/swrs_sequencer_asserts.sv
// Purpose: Port level checks on the warm reset sequencer.
// Assumes: Timings as set in swrs_pkg.
// Notes: Bound to every swrs_sequencer instance.
`timescale 1ns/100ps
module swrs_sequencer_asserts (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Watched outputs.
    input wire logic reset_in_n_oe,
    input wire logic reset_mode_pd_en,
    input wire logic reset_out_n,
    input wire logic config_pull_high,
    input wire logic clock_opt_transparent,
    input wire logic bidir_reset_enable,
    input wire logic io_hiz,
    input wire logic cancel_holds,
    input wire logic abort_ext_cycle,
    input wire logic internal_reset,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic write_strobe_n,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_start,
    input wire logic long_reset_flag,
    input wire logic async_reset_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_entry_outputs: assert property ($rose(internal_reset) |-> io_hiz && !reset_out_n)
        else $error("entry outputs wrong");
    a_abort_pulse: assert property ($rose(internal_reset) |-> abort_ext_cycle ##1 !abort_ext_cycle)
        else $error("abort pulse wrong");
    a_cancel_window: assert property ($rose(cancel_holds) && !async_reset_flag |-> cancel_holds[*6] ##1 !cancel_holds)
        else $error("cancel window wrong");
    a_mode_pulldown: assert property (reset_in_n_oe |=> reset_mode_pd_en)
        else $error("mode pull-down missing");
    a_pull_enable: assert property ($rose(reset_in_n_oe) |-> $past(bidir_reset_enable))
        else $error("pull-down without enable");
    a_clock_open: assert property (clock_opt_transparent |-> long_reset_flag && internal_reset)
        else $error("clock bits open outside long reset");
    a_async_float: assert property (async_reset_flag && internal_reset |-> config_pull_high && io_hiz)
        else $error("asynchronous reset not floating");
    a_exit_idle: assert property (fetch_start |-> !internal_reset && rd_n && write_strobe_n && !ale
        && fetch_addr == 24'h000000 ##1 !fetch_start)
        else $error("exit state wrong");
endmodule : swrs_sequencer_asserts

bind swrs_sequencer swrs_sequencer_asserts u_swrs_sequencer_asserts (.*);

// File: testbench/swrs_sequencer_tb.sv
// Purpose: Self-checking bench for the warm reset sequencer.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: Covers short, long, software and converted resets.
`timescale 1ns/100ps
module swrs_sequencer_tb;
    import swrs_pkg::*;
    logic mclk = 0, rst = 1, press = 0, mode_drop = 0;
    logic filtered_reset_n, reset_in_n_i, reset_in_n_o, reset_in_n_oe, reset_mode_pin;
    logic reset_mode_pd_en, reset_out_n, config_pull_high, clock_opt_transparent;
    logic external_access_sel_n = 0, flash_init_done = 0, software_reset_instr = 0, end_of_init = 0;
    logic bidir_write = 0, bidir_write_value = 0, bidir_reset_enable;
    logic io_hiz, cancel_holds, abort_ext_cycle, internal_reset, ale, rd_n, write_strobe_n, fetch_start;
    logic short_reset_flag, long_reset_flag, async_reset_flag;
    logic [23:0] fetch_addr;
    logic [CFG_W-1:0] config_port = 16'h0000, system_config, port, old;
    int fail_count = 0, num_checks = 0, run_cnt = 0, cycles = 0, n;

    always #2 mclk = ~mclk;

    swrs_sequencer u_swrs_sequencer (.*);
    swrs_partner u_swrs_partner (.mclk(mclk), .press(press), .mode_drop(mode_drop),
        .reset_in_n_o(reset_in_n_o), .reset_in_n_oe(reset_in_n_oe), .reset_in_n_i(reset_in_n_i),
        .filtered_reset_n(filtered_reset_n), .reset_mode_pin(reset_mode_pin));

    // Cycles spent in internal reset, and a ceiling well above the full run.
    always @(posedge mclk) begin
        run_cnt = internal_reset ? run_cnt + 1 : 0;
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            final_report();
        end
    end

    function automatic logic [15:0] sw_cfg(logic [15:0] prev, logic [15:0] pins);
        return {prev[15:13], pins[12:8], 6'h3f, prev[1:0]};
    endfunction : sw_cfg

    task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(int k);
        repeat (k) @(negedge mclk);
    endtask : cyc

    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        // A wait that runs out is a hang and counts as a mismatch.
        if (s !== v) begin
            fail_count++;
            $display("BAD wait expected %b seen %b", v, s);
        end
    endtask : wait_for

    task automatic arm();
        bidir_write <= 1;
        bidir_write_value <= 1;
        cyc(1);
        bidir_write <= 0;
        check("bidir_en", bidir_reset_enable, 1);
    endtask : arm

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        void'($urandom(26));
        cyc(3);
        rst <= 0;
        cyc(3);
        // Short hardware reset, pull-down armed, external boot.
        port = 16'($urandom);
        config_port <= port;
        arm();
        press <= 1;
        cyc(6);
        press <= 0;
        cyc(200);
        check("pin_pull", reset_in_n_oe, 1);
        check("warm_run", internal_reset, 1);
        check("warm_sync", async_reset_flag, 0);
        check("io_float", io_hiz, 1);
        wait_for(short_reset_flag, 1);
        check("seq_len", run_cnt, 522);
        check("long", long_reset_flag, 0);
        wait_for(fetch_start, 1);
        check("cfg_hw", system_config, port);
        check("fetch_zero", fetch_addr, 24'h000000);
        check("bidir_clr", bidir_reset_enable, 0);
        check("rst_out", reset_out_n, 0);
        end_of_init <= 1;
        cyc(1);
        end_of_init <= 0;
        cyc(1);
        check("rst_out_rel", reset_out_n, 1);
        check("mode_pd_off", reset_mode_pd_en, 0);
        // Long hardware reset with internal boot waiting on the memory.
        external_access_sel_n <= 1;
        press <= 1;
        wait_for(long_reset_flag, 1);
        check("short", short_reset_flag, 1);
        check("clk_open", clock_opt_transparent, 1);
        check("mode_pd_on", reset_mode_pd_en, 1);
        port = 16'($urandom);
        config_port <= port;
        cyc(4);
        check("clk_follow", system_config[15:13], port[15:13]);
        press <= 0;
        wait_for(clock_opt_transparent, 0);
        check("clk_close", n <= 9, 1);
        cyc(20);
        check("flash_hold", internal_reset, 1);
        flash_init_done <= 1;
        wait_for(fetch_start, 1);
        check("cfg_long", system_config, port);
        // Software reset; the mode pin drops in mid-sequence.
        old = port;
        arm();
        port = 16'($urandom);
        config_port <= port;
        software_reset_instr <= 1;
        cyc(1);
        software_reset_instr <= 0;
        cyc(100);
        check("sw_pull", reset_in_n_oe, 1);
        mode_drop <= 1;
        cyc(10);
        check("sw_drop", reset_in_n_oe, 0);
        check("sw_sync", async_reset_flag, 0);
        mode_drop <= 0;
        wait_for(short_reset_flag, 1);
        check("sw_len", run_cnt, 522);
        check("sw_long", long_reset_flag, 0);
        wait_for(fetch_start, 1);
        check("cfg_sw", system_config, sw_cfg(old, port));
        // Hardware reset turned asynchronous by the mode pin.
        press <= 1;
        cyc(60);
        mode_drop <= 1;
        cyc(6);
        check("async", async_reset_flag, 1);
        check("pull_hi", config_pull_high, 1);
        mode_drop <= 0;
        cyc(6);
        check("async_keep", config_pull_high, 1);
        press <= 0;
        wait_for(fetch_start, 1);
        check("async_flag", async_reset_flag, 1);
        final_report();
    end
endmodule : swrs_sequencer_tb
